// ---- src/gmii_shim_pkg.sv ----
// Constants and types for the GMII/MII clocking shim
//
// Contract
// - Speed selects reference or PHY transmit timing
// - One transmit timing domain for MAC and user
// - Transmit stream throttled, bytes split to nibbles below gigabit
// - Transmit pins driven from output registers
// - Gigabit forwarded clock from output register
// - Forwarded clock rises mid data window
// - Receive clock sampled on clk, its rise enables receive capture
// - Receive nibbles paired into bytes, enable supplied
// - Each instance owns its transmit/receive clocking
// - Only gigabit reference clock is shared
package gmii_shim_pkg;

    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int FIFO_DEPTH = 32;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int TXC_BIT = 0;
    localparam int RXC_BIT = 1;
    localparam int RXD_LSB = 2;

    typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} speed_t;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } tx_word_t;

    typedef struct packed {
        logic [7:0] data;
        logic en;
        logic er;
    } gmii_tx_t;

    typedef struct packed {
        logic [7:0] data;
        logic dv;
        logic er;
    } gmii_rx_t;

    localparam int PIN_W = RXD_LSB + $bits(gmii_rx_t);

endpackage : gmii_shim_pkg

// ---- src/tx_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth
        $error("FIFO depth must be a power of two of at least two");
    end
    if (WIDTH < 1) begin : bad_width
        $error("FIFO width must be positive");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] wr_ptr_next;
    logic [AW:0] rd_ptr_next;
    logic in_ready_reg;
    logic push;
    logic pop;

    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
    assign in_ready = in_ready_reg;
    assign push = in_valid && in_ready_reg;
    assign pop = out_valid && out_ready;
    assign wr_ptr_next = wr_ptr_reg + (AW + 1)'(push);
    assign rd_ptr_next = rd_ptr_reg + (AW + 1)'(pop);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // ------------------------------------------------------------
    // Pointers and full flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            in_ready_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            in_ready_reg <= (wr_ptr_next - rd_ptr_next) != FULL_CNT;
        end
    end

    fifo_fills_c: cover property (@(posedge clk) disable iff (!reset_n)
        !in_ready_reg);

endmodule : tx_fifo

// ---- src/gmii_phy_shim.sv ----
// GMII/MII transmit and receive clocking shim with transmit FIFO
`timescale 1ns/1ps
module gmii_phy_shim (
    input wire logic clk,
    input wire logic reset_n,
    input gmii_shim_pkg::speed_t speed_sel,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic phy_tx_clk,
    input wire logic phy_rx_clk,
    input gmii_shim_pkg::gmii_rx_t phy_rx,
    output gmii_shim_pkg::gmii_tx_t tx_pins,
    output logic tx_fwd_clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_error,
    output logic rx_end,
    output gmii_shim_pkg::speed_t speed_cur
);
    import gmii_shim_pkg::*;

    function automatic logic is_gig(input speed_t s);
        return s == SPEED_1000;
    endfunction : is_gig

    // ------------------------------------------------------------
    // Pin synchronisers, three stages with agreement filter
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_reg;
    logic [PIN_W-1:0] s2_reg;
    logic [PIN_W-1:0] s3_reg;
    logic [PIN_W-1:0] pin_reg;
    logic [PIN_W-1:0] pin_d_reg;
    logic tx_clk_rise;
    logic rx_clk_rise;
    gmii_rx_t rx_sample;

    assign pin_raw = {phy_rx, phy_rx_clk, phy_tx_clk};

    // Per-instance sampling of this PHY's own clocks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            pin_reg <= '0;
            pin_d_reg <= '0;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
            pin_d_reg <= pin_reg;
        end
    end

    assign tx_clk_rise = pin_reg[TXC_BIT] && !pin_d_reg[TXC_BIT];
    assign rx_clk_rise = pin_reg[RXC_BIT] && !pin_d_reg[RXC_BIT];
    assign rx_sample = gmii_rx_t'(pin_reg[PIN_W-1:RXD_LSB]);

    // ------------------------------------------------------------
    // Speed and transmit timing selection
    // ------------------------------------------------------------
    speed_t speed_reg;
    logic ref_phase_reg;
    logic tx_frame_reg;
    logic rx_frame_reg;
    logic gig;
    logic tx_tick;

    assign gig = is_gig(speed_reg);
    // Reference timing at gigabit, PHY clock edges below
    assign tx_tick = gig ? ref_phase_reg : tx_clk_rise;
    assign speed_cur = speed_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            speed_reg <= SPEED_10;
        end else if (!tx_frame_reg && !rx_frame_reg) begin
            speed_reg <= speed_sel;
        end
    end

    // Per-instance reference phase, common clk of all instances
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_phase_reg <= 1'b0;
        end else begin
            ref_phase_reg <= !ref_phase_reg;
        end
    end

    // ------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------
    logic [$bits(tx_word_t)-1:0] fifo_out;
    tx_word_t fifo_word;
    logic fifo_valid;
    logic fifo_pop;
    logic nib_hi_reg;

    assign fifo_word = tx_word_t'(fifo_out);
    // Byte taken per enabled cycle, per nibble pair below gigabit
    assign fifo_pop = tx_tick && fifo_valid && (gig || !nib_hi_reg);

    tx_fifo #(.WIDTH($bits(tx_word_t)), .DEPTH(FIFO_DEPTH)) fifo_u (
        .clk(clk),
        .reset_n(reset_n),
        .in_data({tx_last, tx_data}),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ------------------------------------------------------------
    // Transmit output registers
    // ------------------------------------------------------------
    gmii_tx_t tx_pins_reg;
    logic [3:0] hi_nib_reg;
    logic hi_last_reg;
    logic tx_fwd_clk_reg;

    assign tx_pins = tx_pins_reg;
    assign tx_fwd_clk = tx_fwd_clk_reg;

    // One timing domain for core and user side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pins_reg <= '0;
            nib_hi_reg <= 1'b0;
            hi_nib_reg <= NIB_ZERO;
            hi_last_reg <= 1'b0;
            tx_frame_reg <= 1'b0;
        end else if (tx_tick) begin
            if (!gig && nib_hi_reg) begin
                tx_pins_reg <= '{data: {NIB_ZERO, hi_nib_reg},
                                 en: 1'b1, er: 1'b0};
                nib_hi_reg <= 1'b0;
                tx_frame_reg <= !hi_last_reg;
            end else if (fifo_valid) begin
                if (gig) begin
                    tx_pins_reg <= '{data: fifo_word.data,
                                     en: 1'b1, er: 1'b0};
                    tx_frame_reg <= !fifo_word.last;
                end else begin
                    tx_pins_reg <= '{data: {NIB_ZERO, fifo_word.data[3:0]},
                                     en: 1'b1, er: 1'b0};
                    hi_nib_reg <= fifo_word.data[7:4];
                    hi_last_reg <= fifo_word.last;
                    nib_hi_reg <= 1'b1;
                    tx_frame_reg <= 1'b1;
                end
            end else if (tx_frame_reg) begin
                // Underrun inside a frame: flag error and end it
                tx_pins_reg <= '{data: BYTE_ZERO, en: 1'b1, er: 1'b1};
                tx_frame_reg <= 1'b0;
            end else begin
                tx_pins_reg <= '{data: BYTE_ZERO, en: 1'b0, er: 1'b0};
            end
        end
    end

    // Forwarded clock low at data update, high mid window
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_fwd_clk_reg <= 1'b0;
        end else begin
            tx_fwd_clk_reg <= gig ? !ref_phase_reg : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive capture and nibble pairing
    // ------------------------------------------------------------
    logic rx_hi_reg;
    logic [3:0] rx_low_reg;
    logic rx_err_acc_reg;
    logic [7:0] rx_data_reg;
    logic rx_valid_reg;
    logic rx_error_reg;
    logic rx_end_reg;

    assign rx_data = rx_data_reg;
    assign rx_valid = rx_valid_reg;
    assign rx_error = rx_error_reg;
    assign rx_end = rx_end_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_hi_reg <= 1'b0;
            rx_low_reg <= NIB_ZERO;
            rx_err_acc_reg <= 1'b0;
            rx_data_reg <= BYTE_ZERO;
            rx_valid_reg <= 1'b0;
            rx_error_reg <= 1'b0;
            rx_end_reg <= 1'b0;
            rx_frame_reg <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            rx_end_reg <= 1'b0;
            if (rx_clk_rise && rx_sample.dv) begin
                rx_frame_reg <= 1'b1;
                if (gig) begin
                    rx_data_reg <= rx_sample.data;
                    rx_error_reg <= rx_sample.er;
                    rx_valid_reg <= 1'b1;
                end else if (!rx_hi_reg) begin
                    rx_low_reg <= rx_sample.data[3:0];
                    rx_err_acc_reg <= rx_sample.er;
                    rx_hi_reg <= 1'b1;
                end else begin
                    rx_data_reg <= {rx_sample.data[3:0], rx_low_reg};
                    rx_error_reg <= rx_err_acc_reg || rx_sample.er;
                    rx_valid_reg <= 1'b1;
                    rx_hi_reg <= 1'b0;
                end
            end else if (rx_clk_rise && rx_frame_reg) begin
                rx_end_reg <= 1'b1;
                rx_frame_reg <= 1'b0;
                rx_hi_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    low_tick_src_a: assert property (
        !gig && tx_tick |-> pin_reg[TXC_BIT] && !$past(pin_reg[TXC_BIT]))
        else $error("Low speed tick not from PHY clock");
    fwd_clk_mid_a: assert property (
        gig && tx_tick ##1 gig |-> !tx_fwd_clk_reg ##1 tx_fwd_clk_reg)
        else $error("Forwarded clock not centred on data");
    fwd_clk_off_a: assert property (
        !gig |=> !tx_fwd_clk_reg)
        else $error("Forwarded clock active below gigabit");
    tx_pins_hold_a: assert property (
        !tx_tick |=> $stable(tx_pins_reg))
        else $error("Transmit pins changed without tick");
    gig_pop_space_a: assert property (
        gig && fifo_pop |=> !fifo_pop)
        else $error("Gigabit bytes taken back to back");
    nib_pair_pop_a: assert property (
        !gig && fifo_pop |=> nib_hi_reg && tx_pins_reg.en)
        else $error("Low nibble not sent after byte taken");
    rx_hold_a: assert property (
        !rx_clk_rise |=> $stable(rx_data_reg))
        else $error("Receive data changed without clock edge");
    rx_gig_byte_a: assert property (
        gig && rx_clk_rise && rx_sample.dv
        |=> rx_valid_reg && rx_data_reg == $past(rx_sample.data))
        else $error("Gigabit receive byte not delivered");
    rx_pulse_a: assert property (
        rx_valid_reg |=> !rx_valid_reg)
        else $error("Receive valid longer than one cycle");

    gig_frame_c: cover property (gig && tx_pins_reg.en ##2 tx_pins_reg.en);
    nib_frame_c: cover property (!gig && nib_hi_reg && tx_tick);
    underrun_c: cover property (tx_pins_reg.er);
    rx_low_byte_c: cover property (!gig && rx_valid_reg);

endmodule : gmii_phy_shim

// ---- verif/phy_model.sv ----
// PHY model: MII/GMII clocks, receive frames, transmit capture
`timescale 1ns/1ps
module phy_model (
    input wire logic tx_run,
    input gmii_shim_pkg::gmii_tx_t tx_pins,
    input wire logic tx_fwd_clk,
    output logic phy_tx_clk,
    output logic phy_rx_clk,
    output gmii_shim_pkg::gmii_rx_t phy_rx
);
    import gmii_shim_pkg::*;
    logic [8:0] tx_q[$];
    logic [3:0] lo_nib;
    logic half;
    int hi_bad;
    int er_seen;
    // ----------------------------------------
    // Transmit clock, stopped outside test use
    // ----------------------------------------
    initial begin
        phy_tx_clk = 1'b0;
        phy_rx_clk = 1'b0;
        phy_rx = '0;
        half = 1'b0;
        hi_bad = 0;
        er_seen = 0;
        forever begin
            #400;
            phy_tx_clk = tx_run ? ~phy_tx_clk : 1'b0;
        end
    end
    // ----------------------------------------
    // Capture, nibble pairs or whole bytes
    // ----------------------------------------
    always @(posedge phy_tx_clk) begin
        if (tx_pins.en !== 1'b1) begin
            half <= 1'b0;
        end else begin
            if (tx_pins.data[7:4] !== NIB_ZERO) hi_bad <= hi_bad + 1;
            if (tx_pins.er === 1'b1) er_seen <= er_seen + 1;
            if (!half) lo_nib <= tx_pins.data[3:0];
            else tx_q.push_back({tx_pins.er, tx_pins.data[3:0], lo_nib});
            half <= ~half;
        end
    end
    always @(posedge tx_fwd_clk) begin
        if (tx_pins.en === 1'b1) tx_q.push_back({tx_pins.er, tx_pins.data});
    end
    // ----------------------------------------
    // Receive, data set mid-way between edges
    // ----------------------------------------
    task automatic rx_edge(input logic [7:0] d, input logic dv,
                           input logic er);
        phy_rx = '{data: d, dv: dv, er: er};
        #400 phy_rx_clk = 1'b1;
        #400 phy_rx_clk = 1'b0;
    endtask : rx_edge
    task automatic send_rx(input logic [7:0] b[$], input logic nib,
                           input int err_at, input logic odd);
        foreach (b[i]) begin
            if (nib) begin
                rx_edge({~b[i][3:0], b[i][3:0]}, 1'b1, i == err_at);
                rx_edge({~b[i][7:4], b[i][7:4]}, 1'b1, 1'b0);
            end else begin
                rx_edge(b[i], 1'b1, i == err_at);
            end
        end
        if (odd) rx_edge(8'h5a, 1'b1, 1'b0);
        rx_edge(~phy_rx.data, 1'b0, 1'b0);
        phy_rx.data = ~phy_rx.data;
    endtask : send_rx
endmodule : phy_model

// ---- verif/gmii_phy_shim_tb.sv ----
// Self-checking bench for the GMII/MII clocking shim
`timescale 1ns/1ps
module gmii_phy_shim_tb;
    import gmii_shim_pkg::*;
    logic clk, reset_n, tx_last, tx_valid, tx_ready, tx_run;
    logic phy_tx_clk, phy_rx_clk, tx_fwd_clk, rx_valid, rx_error, rx_end;
    logic [7:0] tx_data, rx_data;
    speed_t speed_sel, speed_cur;
    gmii_rx_t phy_rx;
    gmii_tx_t tx_pins;
    logic [8:0] rx_q[$];
    int err_count, checked, cycles, ends, stalls;

    gmii_phy_shim dut_u (.clk(clk), .reset_n(reset_n),
        .speed_sel(speed_sel), .tx_data(tx_data), .tx_last(tx_last),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .phy_tx_clk(phy_tx_clk),
        .phy_rx_clk(phy_rx_clk), .phy_rx(phy_rx), .tx_pins(tx_pins),
        .tx_fwd_clk(tx_fwd_clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_error(rx_error), .rx_end(rx_end), .speed_cur(speed_cur));
    phy_model phy_u (.tx_run(tx_run), .tx_pins(tx_pins),
        .tx_fwd_clk(tx_fwd_clk), .phy_tx_clk(phy_tx_clk),
        .phy_rx_clk(phy_rx_clk), .phy_rx(phy_rx));

    // ----------------------------------------
    // Clock, timeout, receive monitor
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    always @(negedge clk) begin
        if (rx_valid === 1'b1) rx_q.push_back({rx_error, rx_data});
        if (rx_end === 1'b1) ends++;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] expd);
        checked++;
        if (seen !== expd) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, expd);
        end
    endtask : check
    task automatic print_verdict();
        $display("counts: checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic push(input logic [7:0] d, input logic last);
        tx_data = d;
        tx_last = last;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) begin
            stalls++;
            @(negedge clk);
        end
        @(negedge clk);
    endtask : push
    task automatic set_speed(input speed_t s);
        speed_sel = s;
        repeat (4) @(negedge clk);
        check(9'(speed_cur), 9'(s));
    endtask : set_speed
    task automatic expect_tx(input int n, input logic [7:0] base,
                             input logic [7:0] step);
        int w;
        for (w = 0; w < 4000 && phy_u.tx_q.size() < n; w++) @(negedge clk);
        check(9'(phy_u.tx_q.size()), 9'(n));
        while (phy_u.tx_q.size() > 0) begin
            check(phy_u.tx_q.pop_front(), {1'b0, base});
            base += step;
        end
    endtask : expect_tx
    task automatic expect_rx(input logic [8:0] e[$], input int end0);
        check(9'(rx_q.size()), 9'(e.size()));
        foreach (e[i]) check(rx_q[i], e[i]);
        check(9'(ends - end0), 9'h001);
        rx_q.delete();
    endtask : expect_rx
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(9'(tx_ready), 9'h000);
        check(9'(speed_cur), 9'(SPEED_10));
        check(9'(tx_pins.data), 9'h000);
        check(9'({tx_pins.en, tx_pins.er, tx_fwd_clk}), 9'h000);
        reset_n = 1'b1;
        @(negedge clk);
        check(9'(tx_ready), 9'h001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_tx_gig();
        int i;
        set_speed(SPEED_1000);
        for (i = 0; i < 4; i++) push(8'h40 + 8'(i), i == 3);
        tx_valid = 1'b0;
        expect_tx(4, 8'h40, 8'h01);
        $display("test gigabit transmit done");
    endtask : t_tx_gig
    task automatic t_tx_100();
        int i;
        set_speed(SPEED_100);
        tx_run = 1'b1;
        for (i = 0; i < 3; i++) push(8'hc3 + 8'(i * 17), i == 2);
        tx_valid = 1'b0;
        expect_tx(3, 8'hc3, 8'h11);
        repeat (20) @(negedge clk);
        check(9'(tx_pins.en), 9'h000);
        check(9'(tx_fwd_clk), 9'h000);
        check(9'(phy_u.hi_bad), 9'h000);
        tx_run = 1'b0;
        $display("test 100 transmit done");
    endtask : t_tx_100
    task automatic t_underrun();
        int i;
        set_speed(SPEED_100);
        tx_run = 1'b1;
        for (i = 0; i < 2; i++) push(8'h71 + 8'(i), 1'b0);
        tx_valid = 1'b0;
        expect_tx(2, 8'h71, 8'h01);
        repeat (30) @(negedge clk);
        check(9'(phy_u.er_seen), 9'h001);
        check(9'(tx_pins.en), 9'h000);
        tx_run = 1'b0;
        $display("test underrun done");
    endtask : t_underrun
    task automatic t_fifo_10();
        int i;
        set_speed(SPEED_10);
        stalls = 0;
        for (i = 0; i < FIFO_DEPTH; i++) push(8'(i), 1'b0);
        check(9'(stalls), 9'h000);
        tx_data = 8'(FIFO_DEPTH);
        tx_last = 1'b1;
        repeat (5) @(negedge clk);
        check(9'(tx_ready), 9'h000);
        tx_run = 1'b1;
        push(8'(FIFO_DEPTH), 1'b1);
        tx_valid = 1'b0;
        expect_tx(FIFO_DEPTH + 1, 8'h00, 8'h01);
        repeat (20) @(negedge clk);
        check(9'(tx_pins.en), 9'h000);
        tx_run = 1'b0;
        $display("test fifo full done");
    endtask : t_fifo_10
    task automatic t_rx();
        int e0;
        set_speed(SPEED_100);
        e0 = ends;
        phy_u.send_rx({8'ha5, 8'h3c, 8'hf0}, 1'b1, 1, 1'b1);
        repeat (10) @(negedge clk);
        expect_rx({9'h0a5, 9'h13c, 9'h0f0}, e0);
        set_speed(SPEED_1000);
        e0 = ends;
        phy_u.send_rx({8'h11, 8'he7}, 1'b0, 0, 1'b0);
        repeat (10) @(negedge clk);
        expect_rx({9'h111, 9'h0e7}, e0);
        $display("test receive done");
    endtask : t_rx
    initial begin
        reset_n = 1'b0;
        speed_sel = SPEED_10;
        tx_data = BYTE_ZERO;
        tx_last = 1'b0;
        tx_valid = 1'b0;
        tx_run = 1'b0;
        err_count = 0;
        checked = 0;
        cycles = 0;
        ends = 0;
        stalls = 0;
        repeat (10) @(negedge clk);
        t_reset();
        t_tx_gig();
        t_tx_100();
        t_underrun();
        t_fifo_10();
        t_rx();
        print_verdict();
    end
endmodule : gmii_phy_shim_tb
